// >>> hw/eps_pkg.sv
// Constants for the network port statistics bank.
// Assumes a 100 MHz module clock and no software register bus.
package eps_pkg;
	localparam int CNT_W = 16;
	localparam int NUM_CNT = 18;
	localparam int DROP_W = 8;
	localparam int NUM_DROPS = 8;
	localparam logic [7:0] DROP_EMPTY = 8'hff;
	localparam logic [7:0] BUF_LIMIT_DEF = 8'h10;
	localparam logic [4:0] COLL_LIMIT = 5'h10;
	localparam int CLK_HZ = 100000000;
	localparam int ERR_HOLD_MS = 1000;
	localparam int ERR_HOLD_CYC = (CLK_HZ / 1000) * ERR_HOLD_MS;
	// Counter indices
	localparam int C_VALID_RX = 0;
	localparam int C_NOBUF_LOST = 1;
	localparam int C_RETRY_RX = 2;
	localparam int C_INT_GEN = 3;
	localparam int C_INT_FAIL = 4;
	localparam int C_SENT_ACK = 5;
	localparam int C_RETRY_LOST = 6;
	localparam int C_TX_RETRY = 7;
	localparam int C_UNROUTE = 8;
	localparam int C_ILLEGAL = 9;
	localparam int C_PRI_RD = 10;
	localparam int C_PRI_WR = 11;
	localparam int C_NP_RD = 12;
	localparam int C_NP_WR = 13;
	localparam int C_FRM_TX = 14;
	localparam int C_FRM_RX = 15;
	localparam int C_COLL = 16;
	localparam int C_COLL_LOST = 17;
	localparam int C_CRC_ERR = 18;
	localparam int C_FRAME_ERR = 19;
	localparam int C_SEQ_ERR = 20;
	localparam int NUM_EV = 21;
	// Error-class counters light the indicator
	localparam logic [20:0] ERR_MASK = 21'h1f03d2;
endpackage : eps_pkg

// >>> hw/eps_counter.sv
// One wrapping statistics counter with clear on a write of zero.
// Assumes synchronous active-high reset on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module eps_counter #(
	parameter int W = 16
) (
	input wire logic ref_clk, // Module clock
	input wire logic srst, // Sync reset
	input wire logic inc, // Count one event
	input wire logic wr_en, // Write strobe
	input wire logic [W-1:0] wr_data, // Written value
	output logic [W-1:0] value // Current count
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	// Next count: write of zero clears, an event in the same cycle counts from zero to one
	always_comb begin
		cnt_next = cnt_reg;
		if (wr_en && wr_data == '0)
			cnt_next = '0; // [R24]
		if (inc)
			cnt_next = (wr_en && wr_data == '0) ? W'(1) : W'(cnt_reg + W'(1)); // [R24]
	end

	// Register
	always_ff @(posedge ref_clk) begin
		if (srst)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	assign value = cnt_reg;
endmodule : eps_counter
`default_nettype wire

// >>> hw/eps_stats.sv
// Statistics bank for the networked coax port: event counters,
// last route, buffer gauge, peer sequence table, error indicator.
// Assumes event inputs are one-cycle pulses synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
// Function
// [R1] Error increment lights indicator one second
// [R2] Count valid received command/reply packets
// [R3] Full buffers drop incoming, count lost
// [R4] Count remote retry requests
// [R5] Count internally generated messages
// [R6] Internal message without buffer discarded, counted
// [R7] Count sent packets acknowledged
// [R8] NAK or no ACK counts retry
// [R9] Retries exhausted abandon and count
// [R10] Unrouteable packet discarded, counted
// [R11] Count illegal operation requests
// [R12] Count local priority reads
// [R13] Count local priority writes
// [R14] Count non-priority writes, reads separately
// [R15] Count every transmitted frame
// [R16] Count every received frame
// [R17] Hold last route, empty unused drops
// [R18] Count collisions
// [R19] Over 16 collisions abandon, count
// [R20] Count checksum failures
// [R21] Count framing faults
// [R22] Wrong sequence counts and sends reject
// [R23] Live gauge of buffers in use
// [R24] 16-bit wrapping counters, zero write clears
module eps_stats #(
	parameter int NUM_PEERS = 16,
	parameter int ERR_HOLD = eps_pkg::ERR_HOLD_CYC,
	parameter logic [7:0] BUF_LIMIT = eps_pkg::BUF_LIMIT_DEF
) (
	input wire logic ref_clk, // Module clock
	input wire logic srst, // Sync reset, active high
	input wire logic rx_frame, // Frame taken from network
	input wire logic rx_crc_bad, // Frame checksum failed
	input wire logic rx_framing_bad, // Frame framing fault
	input wire logic rx_packet, // Command/reply packet received
	input wire logic [$clog2(NUM_PEERS)-1:0] rx_peer, // Sending peer index
	input wire logic [7:0] rx_seq, // Packet sequence number
	input wire logic rx_routed, // Route resolves
	input wire logic rx_illegal_op, // Unsupported operation
	input wire logic rx_retry_req, // Remote asks retransmission
	input wire logic [1:0] rx_local_op, // 0 none 1 pri rd 2 pri wr 3 np
	input wire logic rx_np_write, // Non-priority op is a write
	input wire logic [3:0] rx_route_len, // Drops in route
	input wire logic [63:0] rx_route, // Drops, drop 0 in low byte
	input wire logic int_gen, // Internal message request
	input wire logic buf_release, // A buffer is freed
	input wire logic tx_frame, // Frame put on network
	input wire logic tx_ack, // Positive acknowledgement
	input wire logic tx_nak, // NAK or ACK timeout
	input wire logic [3:0] retry_limit, // Retries allowed
	input wire logic tx_collision, // Collision on send
	input wire logic clr_en, // Counter write strobe
	input wire logic [4:0] clr_sel, // Counter selected
	input wire logic [15:0] clr_data, // Value written
	output logic network_error_indicator, // Error light
	output logic sequence_reject_nak, // Send reject NAK to peer
	output logic [$clog2(NUM_PEERS)-1:0] nak_peer, // Peer for NAK
	output logic pkt_accept, // Packet given a buffer
	output logic tx_abandon, // Current packet dropped
	output logic tx_resend, // Resend current packet
	output logic [7:0] buf_in_use, // Buffer gauge
	output logic [63:0] last_route, // Last route drops
	output logic [21*16-1:0] counters // All counters packed
);
	localparam int PW = $clog2(NUM_PEERS);
	localparam int HW = $clog2(ERR_HOLD + 1);

	logic [eps_pkg::NUM_EV-1:0] ev;
	logic [7:0] seq_reg [NUM_PEERS];
	logic [7:0] seq_next [NUM_PEERS];
	logic [7:0] buf_reg, buf_next;
	logic [63:0] route_reg, route_next;
	logic [3:0] retry_reg, retry_next;
	logic [4:0] coll_reg, coll_next;
	logic [HW-1:0] hold_reg, hold_next;
	logic err_reg, err_next;
	logic nak_reg, nak_next;
	logic [PW-1:0] nakp_reg, nakp_next;
	logic acc_reg, acc_next;
	logic ab_reg, ab_next;
	logic rs_reg, rs_next;
	logic buf_full, rx_good, seq_ok, alloc_rx, alloc_int, rel, retry_out, coll_out;

	// Receive acceptance decode
	always_comb begin
		buf_full = buf_reg >= BUF_LIMIT;
		rx_good = rx_packet && !rx_crc_bad && !rx_framing_bad;
		seq_ok = rx_seq == seq_reg[rx_peer];
		alloc_rx = rx_good && seq_ok && rx_routed && !rx_illegal_op && !buf_full; // [R3]
		alloc_int = int_gen && !buf_full && !alloc_rx; // [R6]
		rel = buf_release && buf_reg != 8'h00;
		retry_out = tx_nak && retry_reg >= retry_limit; // [R9]
		coll_out = tx_collision && coll_reg >= eps_pkg::COLL_LIMIT; // [R19]
	end

	// Event pulses per counter
	always_comb begin
		ev = '0;
		ev[eps_pkg::C_VALID_RX] = rx_good && seq_ok; // [R2]
		ev[eps_pkg::C_NOBUF_LOST] = rx_good && seq_ok && rx_routed && !rx_illegal_op
			&& buf_full; // [R3]
		ev[eps_pkg::C_RETRY_RX] = rx_retry_req; // [R4]
		ev[eps_pkg::C_INT_GEN] = int_gen; // [R5]
		ev[eps_pkg::C_INT_FAIL] = int_gen && !alloc_int; // [R6]
		ev[eps_pkg::C_SENT_ACK] = tx_ack; // [R7]
		ev[eps_pkg::C_RETRY_LOST] = retry_out; // [R9]
		ev[eps_pkg::C_TX_RETRY] = tx_nak && !retry_out; // [R8]
		ev[eps_pkg::C_UNROUTE] = rx_good && seq_ok && !rx_routed; // [R10]
		ev[eps_pkg::C_ILLEGAL] = rx_good && seq_ok && rx_routed && rx_illegal_op; // [R11]
		ev[eps_pkg::C_PRI_RD] = rx_good && seq_ok && rx_local_op == 2'h1; // [R12]
		ev[eps_pkg::C_PRI_WR] = rx_good && seq_ok && rx_local_op == 2'h2; // [R13]
		ev[eps_pkg::C_NP_RD] = rx_good && seq_ok && rx_local_op == 2'h3 && !rx_np_write; // [R14]
		ev[eps_pkg::C_NP_WR] = rx_good && seq_ok && rx_local_op == 2'h3 && rx_np_write; // [R14]
		ev[eps_pkg::C_FRM_TX] = tx_frame; // [R15]
		ev[eps_pkg::C_FRM_RX] = rx_frame; // [R16]
		ev[eps_pkg::C_COLL] = tx_collision; // [R18]
		ev[eps_pkg::C_COLL_LOST] = coll_out; // [R19]
		ev[eps_pkg::C_CRC_ERR] = rx_packet && rx_crc_bad; // [R20]
		ev[eps_pkg::C_FRAME_ERR] = rx_packet && rx_framing_bad && !rx_crc_bad; // [R21]
		ev[eps_pkg::C_SEQ_ERR] = rx_good && !seq_ok; // [R22]
	end

	// One counter per event
	genvar gi;
	generate
		for (gi = 0; gi < eps_pkg::NUM_EV; gi++) begin : g_cnt
			eps_counter #(.W(eps_pkg::CNT_W)) u_cnt (
				.ref_clk(ref_clk),
				.srst(srst),
				.inc(ev[gi]),
				.wr_en(clr_en && clr_sel == 5'(gi)),
				.wr_data(clr_data),
				.value(counters[gi*16 +: 16])
			);
		end
	endgenerate

	// Buffer gauge: one up per allocation, one down per release
	// An allocation and a release in one cycle cancel out
	always_comb begin
		buf_next = buf_reg;
		if ((alloc_rx || alloc_int) && !rel)
			buf_next = 8'(buf_reg + 8'h01); // [R23]
		else if (rel && !(alloc_rx || alloc_int))
			buf_next = 8'(buf_reg - 8'h01); // [R23]
	end

	// Gauge register
	always_ff @(posedge ref_clk) begin
		if (srst)
			buf_reg <= 8'h00;
		else
			buf_reg <= buf_next;
	end

	// Last route: drops past the length read as empty
	always_comb begin
		route_next = route_reg;
		if (rx_good && seq_ok) begin
			for (int i = 0; i < eps_pkg::NUM_DROPS; i++)
				route_next[i*8 +: 8] = (4'(i) < rx_route_len) ? rx_route[i*8 +: 8]
					: eps_pkg::DROP_EMPTY; // [R17]
		end
	end

	// Route register; all drops read zero until the first message
	always_ff @(posedge ref_clk) begin
		if (srst)
			route_reg <= '0;
		else
			route_reg <= route_next;
	end

	// Peer sequence table: advance only on an in-order packet
	always_comb begin
		for (int p = 0; p < NUM_PEERS; p++)
			seq_next[p] = seq_reg[p];
		if (rx_good && seq_ok)
			seq_next[rx_peer] = 8'(seq_reg[rx_peer] + 8'h01); // [R22]
	end

	// Sequence registers; every peer expects zero after reset
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int p = 0; p < NUM_PEERS; p++)
				seq_reg[p] <= 8'h00;
		end else begin
			for (int p = 0; p < NUM_PEERS; p++)
				seq_reg[p] <= seq_next[p];
		end
	end

	// Retry tally: cleared by an ACK or by giving up
	always_comb begin
		retry_next = retry_reg;
		if (tx_ack || retry_out)
			retry_next = 4'h0; // [R9]
		else if (tx_nak)
			retry_next = 4'(retry_reg + 4'h1); // [R8]
	end

	// Retry tally register
	always_ff @(posedge ref_clk) begin
		if (srst)
			retry_reg <= 4'h0;
		else
			retry_reg <= retry_next;
	end

	// Collision tally: cleared by an ACK or by giving up
	always_comb begin
		coll_next = coll_reg;
		if (tx_ack || coll_out)
			coll_next = 5'h00; // [R19]
		else if (tx_collision)
			coll_next = 5'(coll_reg + 5'h01); // [R18]
	end

	// Collision tally register
	always_ff @(posedge ref_clk) begin
		if (srst)
			coll_reg <= 5'h00;
		else
			coll_reg <= coll_next;
	end

	// Indicator hold: any error event restarts the count
	// The light drops once the count has run down to zero
	always_comb begin
		hold_next = hold_reg;
		err_next = err_reg;
		if (|(ev & eps_pkg::ERR_MASK)) begin
			hold_next = HW'(ERR_HOLD - 1); // [R1]
			err_next = 1'b1; // [R1]
		end else if (hold_reg != '0) begin
			hold_next = HW'(hold_reg - HW'(1));
		end else begin
			err_next = 1'b0;
		end
	end

	// Indicator registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			hold_reg <= '0;
			err_reg <= 1'b0;
		end else begin
			hold_reg <= hold_next;
			err_reg <= err_next;
		end
	end

	// Reject NAK pulse; the peer is kept until the next reject
	always_comb begin
		nak_next = rx_good && !seq_ok; // [R22]
		nakp_next = nak_next ? rx_peer : nakp_reg; // [R22]
	end

	// Reject NAK registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			nak_reg <= 1'b0;
			nakp_reg <= '0;
		end else begin
			nak_reg <= nak_next;
			nakp_reg <= nakp_next;
		end
	end

	// Accept, abandon and resend pulses
	always_comb begin
		acc_next = alloc_rx; // [R3]
		ab_next = retry_out || coll_out; // [R9] [R19]
		rs_next = tx_nak && !retry_out; // [R8]
	end

	// Pulse registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			acc_reg <= 1'b0;
			ab_reg <= 1'b0;
			rs_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			ab_reg <= ab_next;
			rs_reg <= rs_next;
		end
	end

	assign network_error_indicator = err_reg;
	assign sequence_reject_nak = nak_reg;
	assign nak_peer = nakp_reg;
	assign pkt_accept = acc_reg;
	assign tx_abandon = ab_reg;
	assign tx_resend = rs_reg;
	assign buf_in_use = buf_reg;
	assign last_route = route_reg;
endmodule : eps_stats
`default_nettype wire

// >>> sim/eps_station.sv
// Far-side station model: sends packets to the port, answers its sends.
// Assumes the bank samples its inputs on the rising edge of ref_clk.
`timescale 1ns/1ns
`default_nettype none
module eps_station (
	input wire logic ref_clk, // Clock
	output logic rx_frame, // Frame out
	output logic rx_packet, // Packet out
	output logic [7:0] rx_seq, // Sequence
	output logic rx_crc_bad, // Bad sum
	output logic rx_framing_bad, // Bad framing
	output logic rx_routed, // Route known
	output logic rx_illegal_op, // Bad op
	output logic [1:0] rx_local_op, // Local op
	output logic rx_np_write, // Write
	output logic tx_ack, // Ack
	output logic tx_nak, // Nak
	output logic tx_collision // Collision
);
	// Idle at start
	initial begin
		{rx_frame, rx_packet, rx_seq, tx_ack, tx_nak, tx_collision} = '0;
		{rx_crc_bad, rx_framing_bad, rx_routed, rx_illegal_op, rx_local_op, rx_np_write} = '0;
	end
	// One packet; f is crc, framing, routed, illegal, op, write
	task send(input logic [7:0] s, input logic [6:0] f);
		@(negedge ref_clk);
		{rx_crc_bad, rx_framing_bad, rx_routed, rx_illegal_op, rx_local_op, rx_np_write} = f;
		{rx_frame, rx_packet, rx_seq} = {2'h3, s};
		@(negedge ref_clk);
		{rx_frame, rx_packet, rx_seq} = {2'h0, ~s}; // No stale sequence
	endtask : send
	// Answer a send; a is ack, nak, collision
	task ans(input logic [2:0] a);
		@(negedge ref_clk);
		{tx_ack, tx_nak, tx_collision} = a;
		@(negedge ref_clk);
		{tx_ack, tx_nak, tx_collision} = 3'h0;
	endtask : ans
endmodule : eps_station
`default_nettype wire

// >>> sim/eps_stats_chk.sv
// Assertion checker for the statistics bank, bound into eps_stats.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module eps_stats_chk #(
	parameter logic [7:0] BUF_LIMIT = 8'h10
) (
	input wire logic ref_clk, // Clock
	input wire logic srst, // Reset
	input wire logic rx_packet, // Packet
	input wire logic rx_crc_bad, // Bad sum
	input wire logic rx_frame, // Frame in
	input wire logic tx_frame, // Frame out
	input wire logic tx_collision, // Collision
	input wire logic buf_release, // Freed
	input wire logic network_error_indicator, // Light
	input wire logic pkt_accept, // Accepted
	input wire logic tx_abandon, // Dropped
	input wire logic tx_resend, // Resent
	input wire logic [7:0] buf_in_use, // Gauge
	input wire logic [335:0] counters // Counters
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	logic [15:0] c [21];
	// Unpack the counter bus
	always_comb begin
		for (int k = 0; k < 21; k++) c[k] = counters[16*k+:16];
	end
	sequence crc_in;
		rx_packet && rx_crc_bad;
	endsequence
	err_light_a: assert property (crc_in |=> network_error_indicator)
		else $error("light off");
	gauge_up_a: assert property (pkt_accept && !$past(buf_release) |->
		buf_in_use == $past(buf_in_use) + 8'h1) else $error("gauge");
	gauge_cap_a: assert property (buf_in_use <= BUF_LIMIT)
		else $error("over limit");
	rx_frames_a: assert property (rx_frame |=> c[15] == $past(c[15]) + 16'h1)
		else $error("rx frames");
	tx_frames_a: assert property (tx_frame |=> c[14] == $past(c[14]) + 16'h1)
		else $error("tx frames");
	coll_count_a: assert property (tx_collision |=> c[16] == $past(c[16]) + 16'h1)
		else $error("collisions");
	resend_count_a: assert property (tx_resend |-> c[7] == $past(c[7]) + 16'h1)
		else $error("retries");
	abandon_count_a: assert property (tx_abandon |-> c[6] != $past(c[6]) ||
		c[17] != $past(c[17])) else $error("abandon");
endmodule : eps_stats_chk
bind eps_stats eps_stats_chk #(.BUF_LIMIT(BUF_LIMIT)) eps_stats_chk_i (.*);
`default_nettype wire

// >>> sim/tb_eps_stats.sv
// Self-checking testbench for the statistics bank with a station model.
// Assumes each event shows at the outputs one cycle after its pulse.
`timescale 1ns/1ns
`default_nettype none
module tb_eps_stats;
	logic ref_clk, srst, rx_frame, rx_crc_bad, rx_framing_bad, rx_packet, rx_routed;
	logic rx_illegal_op, rx_retry_req, rx_np_write, int_gen, buf_release, tx_frame, tx_ack;
	logic tx_nak, tx_collision, clr_en, network_error_indicator, sequence_reject_nak;
	logic pkt_accept, tx_abandon, tx_resend;
	logic [1:0] rx_local_op;
	logic [3:0] rx_peer, nak_peer, rx_route_len, retry_limit;
	logic [4:0] clr_sel, ev;
	logic [7:0] rx_seq, buf_in_use;
	logic [15:0] clr_data;
	logic [63:0] rx_route, last_route;
	logic [335:0] counters;
	int error_cnt = 0;
	int check_count = 0;
	// Bench-driven event pulses
	assign {rx_retry_req, int_gen, buf_release, tx_frame, clr_en} = ev;
	eps_stats #(.ERR_HOLD(20), .BUF_LIMIT(8'h02)) eps_stats_i (.*);
	eps_station eps_station_i (.*);
	// Clock
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	task chk(input string n, input logic [63:0] s, e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	function logic [15:0] cnt(input int k);
		return counters[16*k+:16];
	endfunction : cnt
	task hit(input logic [4:0] e);
		@(negedge ref_clk);
		ev = e;
		@(negedge ref_clk);
		ev = 5'h00;
	endtask : hit
	task end_of_test;
		if (error_cnt == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	task t_rx;
		eps_station_i.send(8'h00, 7'h10);
		chk("accept", pkt_accept, 1'h1);
		chk("valid", cnt(0), 16'h1);
		chk("gauge", buf_in_use, 8'h1);
		chk("route", last_route, 64'hffff_ffff_ffff_0302);
		chk("frm rx", cnt(15), 16'h1);
		eps_station_i.send(8'h05, 7'h10);
		chk("nak", sequence_reject_nak, 1'h1);
		chk("seq", cnt(20), 16'h1);
		chk("valid kept", cnt(0), 16'h1);
		chk("lit", network_error_indicator, 1'h1);
		// Hold of 20 cycles from the error edge
		repeat (19) @(negedge ref_clk);
		chk("still lit", network_error_indicator, 1'h1);
		@(negedge ref_clk);
		chk("dark", network_error_indicator, 1'h0);
	endtask : t_rx
	task t_buf;
		eps_station_i.send(8'h01, 7'h10);
		eps_station_i.send(8'h02, 7'h10);
		chk("lost", cnt(1), 16'h1);
		chk("full", buf_in_use, 8'h2);
		hit(5'h08);
		chk("gen fail", cnt(4), 16'h1);
		hit(5'h04);
		hit(5'h08);
		chk("gen", buf_in_use, 8'h2);
		chk("int gen", cnt(3), 16'h2);
		repeat (3) hit(5'h04);
		chk("empty", buf_in_use, 8'h0);
	endtask : t_buf
	task t_ops;
		for (int k = 1; k < 5; k++) begin
			rx_peer = 4'(k + 4);
			eps_station_i.send(8'h00, {4'h2, 2'(k < 3 ? k : 3), k == 4});
			chk("local op", cnt(9 + k), 16'h1);
			hit(5'h04);
		end
		eps_station_i.send(8'h07, 7'h10);
		chk("nak peer", nak_peer, 4'h8);
		eps_station_i.send(8'h00, 7'h50);
		chk("crc", cnt(18), 16'h1);
		eps_station_i.send(8'h00, 7'h30);
		chk("framing", cnt(19), 16'h1);
		{rx_route_len, rx_route} = {4'h0, 64'h0807_0605_0403_0201};
		eps_station_i.send(8'h01, 7'h00);
		chk("unroute", cnt(8), 16'h1);
		chk("no route", last_route, 64'hffff_ffff_ffff_ffff);
		rx_route_len = 4'h8;
		eps_station_i.send(8'h02, 7'h18);
		chk("illegal", cnt(9), 16'h1);
		chk("full route", last_route, 64'h0807_0605_0403_0201);
	endtask : t_ops
	task t_tx;
		hit(5'h12);
		chk("frm tx", cnt(14), 16'h1);
		chk("retry rx", cnt(2), 16'h1);
		eps_station_i.ans(3'h4);
		chk("acked", cnt(5), 16'h1);
		eps_station_i.ans(3'h2);
		chk("resend", tx_resend, 1'h1);
		chk("tx retry", cnt(7), 16'h1);
		eps_station_i.ans(3'h2);
		chk("abandon", tx_abandon, 1'h1);
		chk("tries lost", cnt(6), 16'h1);
		// No retries allowed: the first NAK gives up
		retry_limit = 4'h0;
		eps_station_i.ans(3'h2);
		chk("no retry", cnt(6), 16'h2);
		chk("no resend", cnt(7), 16'h1);
		eps_station_i.ans(3'h4);
		repeat (16) eps_station_i.ans(3'h1);
		chk("coll ok", tx_abandon, 1'h0);
		eps_station_i.ans(3'h1);
		chk("coll lost", cnt(17), 16'h1);
		chk("colls", cnt(16), 16'h11);
		{clr_sel, clr_data} = {5'h10, 16'h0000};
		hit(5'h01);
		chk("clear", cnt(16), 16'h0);
		{clr_sel, clr_data} = {5'h0e, 16'h0005};
		hit(5'h01);
		chk("kept", cnt(14), 16'h1);
	endtask : t_tx
	// Main sequence
	initial begin
		{ev, rx_peer, clr_sel, clr_data} = '0;
		{srst, rx_route_len, retry_limit} = 9'h121;
		rx_route = 64'h0302;
		repeat (5) @(negedge ref_clk);
		srst = 1'h0;
		t_rx;
		t_buf;
		t_ops;
		t_tx;
		end_of_test;
	end
	// Watchdog
	initial begin
		#100000;
		error_cnt++;
		end_of_test;
	end
endmodule : tb_eps_stats
`default_nettype wire
